// File: hdl/ccdtg_pkg.sv
// timing constants, sizes and state codes for the ccd timing generator
// assumes a single 200 MHz system clock shared by all users of the package
package ccdtg_pkg;
    // =========================================================
    // clock and widths
    localparam int CLK_MHZ = 200;
    localparam int TMR_W = 12;
    localparam int ROW_W = 10;
    localparam int PH_W = 3;
    localparam int ADC_W = 12;
    localparam int PIX_W = 2 * ADC_W + 1;
    // =========================================================
    // array geometry
    localparam int COLUMN_REGS = 680;
    localparam int HREG_STAGES = 496;
    localparam int ROW_COUNT = 496;
    localparam int DARK_COLS = 32;
    localparam int DARK_ROWS = 12;
    localparam int FIFO_DEPTH = 16;
    // =========================================================
    // horizontal clock: 8 phases per pixel, never above the pixel rate limit
    localparam int H_FMAX_MHZ = 30;
    localparam int H_PERIOD_MIN_CYC = (CLK_MHZ + H_FMAX_MHZ - 1) / H_FMAX_MHZ;
    localparam int H_PHASES = 8;
    localparam int H_PH_RAW = (H_PERIOD_MIN_CYC + H_PHASES - 1) / H_PHASES;
    localparam logic [TMR_W-1:0] H_PH_CYC = TMR_W'((H_PH_RAW < 1) ? 1 : H_PH_RAW);
    localparam logic [PH_W-1:0] PH_STALL = 3'h1;
    localparam logic [PH_W-1:0] PH_RST_ON = 3'h2;
    localparam logic [PH_W-1:0] PH_RST_OFF = 3'h3;
    localparam logic [PH_W-1:0] PH_H2_FALL = 3'h4;
    localparam logic [PH_W-1:0] PH_CAPTURE = 3'h7;
    // =========================================================
    // vertical, retrace and shutter times (least times, rounded up)
    localparam int V1_XFER_NS = 5000;
    localparam int VX_NS = 1000;
    localparam int RETRACE_NS = 2000;
    localparam int SHUTTER_NS = 1000;
    localparam logic [TMR_W-1:0] V1X_CYC = TMR_W'((V1_XFER_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] VX_CYC = TMR_W'((VX_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] RETRACE_CYC = TMR_W'((RETRACE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [TMR_W-1:0] SHUT_CYC = TMR_W'((SHUTTER_NS * CLK_MHZ + 999) / 1000);
    // =========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PD_XFER,
        ST_V2_HI,
        ST_V2_LO,
        ST_AB_XFER,
        ST_A_RET,
        ST_READ,
        ST_RETRACE
    } ccdtg_state_t;
endpackage

// File: hdl/ccdtg_stream_if.sv
// valid/ready word carrier between the sequencer and its pixel fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface ccdtg_stream_if #(parameter int W = 8) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hdl/ccdtg_fifo.sv
// pixel fifo: memory, pointers and a registered read stage
// assumes DEPTH is a power of two so the pointers wrap by themselves
`timescale 1ns/1ps
`default_nettype none
module ccdtg_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // write side
    ccdtg_stream_if.snk wr,
    // read side
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } ccdtg_fifo_st_t;

    ccdtg_fifo_st_t fifo_reg;
    ccdtg_fifo_st_t fifo_next;
    logic push;
    logic pop;

    // ready comes from the count alone, so full really stalls the writer
    assign wr.ready = (fifo_reg.cnt != FULL_CNT);
    assign o_rd_valid = fifo_reg.ov;
    assign o_rd_data = fifo_reg.od;

    // =========================================================
    // next state: write, refill the output register, count
    always_comb begin
        fifo_next = fifo_reg;
        push = wr.valid && (fifo_reg.cnt != FULL_CNT);
        pop = (fifo_reg.cnt != '0) && (!fifo_reg.ov || i_rd_ready);
        if (push) begin
            fifo_next.mem[fifo_reg.wp] = wr.data;
            fifo_next.wp = fifo_reg.wp + 1'b1;
        end
        if (pop) begin
            fifo_next.od = fifo_reg.mem[fifo_reg.rp];
            fifo_next.ov = 1'b1;
            fifo_next.rp = fifo_reg.rp + 1'b1;
        end else if (i_rd_ready) begin
            fifo_next.ov = 1'b0;
        end
        if (push && !pop) begin
            fifo_next.cnt = fifo_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            fifo_next.cnt = fifo_reg.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end
endmodule // ccdtg_fifo
`default_nettype wire

// File: hdl/ccdtg_timing.sv
// ccd timing generator: vertical, horizontal, reset, dump and shutter clocks
// plus pixel capture from two external converters into a 16-word fifo
// assumes converters present settled data on i_adc_* by the capture phase
`timescale 1ns/1ps
`default_nettype none
module ccdtg_timing
    import ccdtg_pkg::*;
#(
    parameter bit SINGLE_OUTPUT = 1'b0,
    parameter int STAGES = ccdtg_pkg::HREG_STAGES,
    parameter int ROWS = ccdtg_pkg::ROW_COUNT
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // frame control, sampled at the start of each frame
    input wire logic i_run,
    input wire logic i_dual_mode,
    input wire logic i_bin_two,
    input wire logic [ccdtg_pkg::ROW_W-1:0] i_dump_rows,
    input wire logic [ccdtg_pkg::ROW_W-1:0] i_shutter_group,
    // converter data pins
    input wire logic [ccdtg_pkg::ADC_W-1:0] i_adc_a,
    input wire logic [ccdtg_pkg::ADC_W-1:0] i_adc_b,
    // sensor clocks
    output logic o_vert_phase_one,
    output logic o_vert_phase_one_xfer,
    output logic o_vert_phase_two,
    output logic o_horiz_a_phase_one,
    output logic o_horiz_b_phase_one,
    output logic o_horiz_phase_two,
    output logic o_reset_clock,
    output logic o_line_dump_gate,
    output logic o_shutter_pulse,
    // pixel stream out
    output logic o_pix_valid,
    output logic [ccdtg_pkg::PIX_W-1:0] o_pix_data,
    input wire logic i_pix_ready,
    // status
    output logic o_frame_busy
);
    import ccdtg_pkg::*;

    typedef struct packed {
        ccdtg_state_t st;
        logic [TMR_W-1:0] tmr;
        logic [PH_W-1:0] ph;
        logic [ROW_W-1:0] row;
        logic [ROW_W-1:0] grow;
        logic [ROW_W-1:0] grp;
        logic [ROW_W-1:0] col;
        logic [1:0] sub;
        logic dual;
        logic bin;
        logic [ROW_W-1:0] dump;
        logic [ROW_W-1:0] shut;
        logic [ADC_W-1:0] a_s1;
        logic [ADC_W-1:0] a_s2;
        logic [ADC_W-1:0] b_s1;
        logic [ADC_W-1:0] b_s2;
        logic push;
        logic [PIX_W-1:0] word;
        logic v1;
        logic v2;
        logic v1x;
        logic h1a;
        logic h1b;
        logic h2;
        logic rst;
        logic line_dump_gate;
        logic shp;
        logic busy;
    } ccdtg_st_t;

    localparam logic [ROW_W-1:0] LAST_COL = ROW_W'(STAGES - 1);
    localparam logic [ROW_W-1:0] ROW_END = ROW_W'(ROWS);
    localparam logic [ROW_W-1:0] DARK_C = ROW_W'(DARK_COLS);
    localparam logic [ROW_W-1:0] DARK_R = ROW_W'(DARK_ROWS);

    ccdtg_st_t tg_reg;
    ccdtg_st_t tg_next;
    logic dumping;
    logic dark;

    ccdtg_stream_if #(.W(PIX_W)) pix_if ();

    assign pix_if.valid = tg_reg.push;
    assign pix_if.data = tg_reg.word;

    // =========================================================
    // pin outputs straight from the state register
    assign o_vert_phase_one = tg_reg.v1;
    assign o_vert_phase_one_xfer = tg_reg.v1x;
    assign o_vert_phase_two = tg_reg.v2;
    assign o_horiz_a_phase_one = tg_reg.h1a;
    assign o_horiz_b_phase_one = tg_reg.h1b;
    assign o_horiz_phase_two = tg_reg.h2;
    assign o_reset_clock = tg_reg.rst;
    assign o_line_dump_gate = tg_reg.line_dump_gate;
    assign o_shutter_pulse = tg_reg.shp;
    assign o_frame_busy = tg_reg.busy;

    // group classification from the row at which the group started
    assign dumping = (tg_reg.grow < tg_reg.dump);
    assign dark = (tg_reg.grow < DARK_R) || (tg_reg.col < DARK_C);

    // =========================================================
    // sequencer
    always_comb begin
        tg_next = tg_reg;
        // converter pins: two flops before any use
        tg_next.a_s1 = i_adc_a;
        tg_next.a_s2 = tg_reg.a_s1;
        tg_next.b_s1 = i_adc_b;
        tg_next.b_s2 = tg_reg.b_s1;
        tg_next.push = 1'b0;
        tg_next.tmr = tg_reg.tmr + 1'b1;
        // quiet levels: charge parked under A and B phase one, phase two low
        tg_next.v1 = 1'b1;
        tg_next.v1x = 1'b0;
        tg_next.h1a = 1'b1;
        tg_next.h1b = 1'b1;
        tg_next.h2 = 1'b0;
        tg_next.rst = 1'b0;
        tg_next.line_dump_gate = 1'b0;
        tg_next.shp = 1'b0;
        unique case (tg_reg.st)
            ST_IDLE: begin
                tg_next.busy = 1'b0;
                tg_next.tmr = '0;
                if (i_run) begin
                    tg_next.dual = i_dual_mode & ~SINGLE_OUTPUT;
                    tg_next.bin = i_bin_two;
                    tg_next.dump = i_dump_rows;
                    tg_next.shut = i_shutter_group;
                    tg_next.row = '0;
                    tg_next.grow = '0;
                    tg_next.grp = '0;
                    tg_next.busy = 1'b1;
                    tg_next.st = ST_PD_XFER;
                end
            end
            ST_PD_XFER: begin
                // whole array into the column registers; its fall ends exposure
                tg_next.v1x = 1'b1;
                if (tg_reg.tmr == V1X_CYC - 1'b1) begin
                    tg_next.v1x = 1'b0;
                    tg_next.tmr = '0;
                    tg_next.sub = 2'h0;
                    tg_next.st = ST_V2_HI;
                end
            end
            ST_V2_HI: begin
                tg_next.v1 = 1'b0;
                tg_next.line_dump_gate = dumping;
                if (tg_reg.tmr == VX_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.v1 = 1'b1;
                    tg_next.st = ST_V2_LO;
                end
            end
            ST_V2_LO: begin
                tg_next.line_dump_gate = dumping;
                if (tg_reg.tmr == VX_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.line_dump_gate = 1'b0;
                    tg_next.row = tg_reg.row + 1'b1;
                    if (tg_reg.bin && !tg_reg.sub[0]) begin
                        // second line lands on the same packets
                        tg_next.sub[0] = 1'b1;
                        tg_next.st = ST_V2_HI;
                        tg_next.v1 = 1'b0;
                        tg_next.line_dump_gate = dumping;
                    end else if (tg_reg.dual && !tg_reg.sub[1]) begin
                        tg_next.sub = 2'h2;
                        tg_next.st = ST_AB_XFER;
                        tg_next.h1a = 1'b0;
                    end else if (dumping) begin
                        tg_next.st = ST_RETRACE;
                    end else begin
                        tg_next.col = '0;
                        tg_next.ph = '0;
                        tg_next.st = ST_READ;
                    end
                end
            end
            ST_AB_XFER: begin
                // A empties into B while phase two stays low
                tg_next.h1a = 1'b0;
                if (tg_reg.tmr == VX_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.h1a = 1'b1;
                    tg_next.st = ST_A_RET;
                end
            end
            ST_A_RET: begin
                // A back high for a full slot before the next line moves in
                if (tg_reg.tmr == VX_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.v1 = 1'b0;
                    tg_next.line_dump_gate = dumping;
                    tg_next.st = ST_V2_HI;
                end
            end
            ST_READ: begin
                // one pixel is 8 phases; phase two high for the first four
                tg_next.h2 = (tg_reg.ph < PH_H2_FALL);
                tg_next.h1a = ~tg_next.h2;
                tg_next.h1b = ~tg_next.h2;
                tg_next.rst = (tg_reg.ph >= PH_RST_ON) && (tg_reg.ph <= PH_RST_OFF);
                if (tg_reg.ph == PH_STALL && !pix_if.ready) begin
                    // fifo full: freeze all clocks mid-pixel until room appears
                    tg_next.tmr = '0;
                    tg_next.rst = 1'b0;
                end else if (tg_reg.tmr >= H_PH_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.ph = tg_reg.ph + 1'b1;
                    if (tg_reg.ph == PH_CAPTURE) begin
                        // sample after the packet settled, reset follows next pixel
                        tg_next.push = 1'b1;
                        tg_next.word = {dark, tg_reg.dual ? tg_reg.b_s2 : {ADC_W{1'b0}},
                                        tg_reg.a_s2};
                        tg_next.col = tg_reg.col + 1'b1;
                        if (tg_reg.col == LAST_COL) begin
                            tg_next.st = ST_RETRACE;
                            tg_next.h2 = 1'b0;
                            tg_next.h1a = 1'b1;
                            tg_next.h1b = 1'b1;
                            tg_next.rst = 1'b0;
                        end
                    end
                end
            end
            ST_RETRACE: begin
                // retrace has fixed length, the shutter only picks its slot
                tg_next.shp = (tg_reg.grp == tg_reg.shut) && (tg_reg.tmr < SHUT_CYC);
                if (tg_reg.tmr == RETRACE_CYC - 1'b1) begin
                    tg_next.tmr = '0;
                    tg_next.shp = 1'b0;
                    tg_next.grp = tg_reg.grp + 1'b1;
                    tg_next.grow = tg_reg.row;
                    tg_next.sub = 2'h0;
                    if (tg_reg.row >= ROW_END) begin
                        tg_next.st = ST_IDLE;
                    end else begin
                        tg_next.v1 = 1'b0;
                        tg_next.line_dump_gate = (tg_reg.row < tg_reg.dump);
                        tg_next.st = ST_V2_HI;
                    end
                end
            end
        endcase
        // phase two gets its own flop so the pin never sees an inverter's skew
        tg_next.v2 = ~tg_next.v1;
    end

    // state register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            tg_reg <= '0;
            tg_reg.v2 <= 1'b1; // phase one parked low, so phase two stays high
        end else begin
            tg_reg <= tg_next;
        end
    end

    // =========================================================
    // pixel buffer; its ready stalls the readout above
    ccdtg_fifo #(
        .W(PIX_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .wr(pix_if.snk),
        .o_rd_valid(o_pix_valid),
        .o_rd_data(o_pix_data),
        .i_rd_ready(i_pix_ready)
    );
endmodule // ccdtg_timing
`default_nettype wire

// File: dv/ccdtg_timing_assertions.sv
// concurrent checks on the sensor clock pins of the ccd timing generator
// assumes it is bound into every ccdtg_timing instance, one clock domain
`timescale 1ns/1ps
`default_nettype none
module ccdtg_timing_assertions #(
    parameter int STAGES = 496,
    parameter int ROWS = 496
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // consumer side
    input wire logic i_pix_ready,
    // sensor clocks and status
    input wire logic o_vert_phase_one,
    input wire logic o_vert_phase_one_xfer,
    input wire logic o_vert_phase_two,
    input wire logic o_horiz_a_phase_one,
    input wire logic o_horiz_b_phase_one,
    input wire logic o_horiz_phase_two,
    input wire logic o_reset_clock,
    input wire logic o_line_dump_gate,
    input wire logic o_shutter_pulse,
    input wire logic o_pix_valid,
    input wire logic [ccdtg_pkg::PIX_W-1:0] o_pix_data,
    input wire logic o_frame_busy
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_sys_rst);
    // =========================================================
    // helper: cycles the shutter has been high so far
    logic [7:0] shut_len_reg;
    logic [7:0] shut_len_next;
    always_comb shut_len_next = o_shutter_pulse ? shut_len_reg + 8'h01 : 8'h00;
    always_ff @(posedge i_clk) shut_len_reg <= i_sys_rst ? 8'h00 : shut_len_next;
    // reset clears the node, then the next packet drops with phase two
    sequence node_reset_s;
        o_reset_clock ##1 (!o_reset_clock && !o_horiz_phase_two);
    endsequence
    // phase two stays low for the rest of the pixel: 4 of its 8 cycles, 25 MHz
    sequence h2_low_s;
        !o_horiz_phase_two [*4];
    endsequence
    vert_compl_a: assert property (o_vert_phase_two == !o_vert_phase_one)
        else $error("vertical phases not complementary");
    horiz_compl_a: assert property (o_horiz_phase_two |->
        !o_horiz_a_phase_one && !o_horiz_b_phase_one)
        else $error("horizontal phases overlap");
    line_into_a_a: assert property ($fell(o_vert_phase_two) |->
        o_horiz_a_phase_one && !o_horiz_phase_two)
        else $error("line moved without register A open");
    a_to_b_a: assert property ($fell(o_horiz_a_phase_one) && !o_horiz_phase_two |->
        (!o_horiz_a_phase_one && o_horiz_b_phase_one && !o_horiz_phase_two) [*8])
        else $error("A to B move malformed");
    a_return_a: assert property ($rose(o_vert_phase_two) |->
        o_horiz_a_phase_one && !o_horiz_phase_two)
        else $error("next line started before A returned");
    node_reset_a: assert property ($rose(o_reset_clock) |-> o_horiz_phase_two ##1 node_reset_s)
        else $error("reset clock out of place");
    pixel_rate_a: assert property ($fell(o_horiz_phase_two) |-> h2_low_s)
        else $error("horizontal clock too fast");
    dump_quiet_a: assert property (o_line_dump_gate |-> !o_horiz_phase_two && !o_reset_clock)
        else $error("dump gate during readout");
    shut_retrace_a: assert property (o_shutter_pulse |->
        !o_horiz_phase_two && !o_reset_clock && !o_vert_phase_one_xfer)
        else $error("shutter outside retrace");
    shut_width_a: assert property ($fell(o_shutter_pulse) |->
        shut_len_reg == 8'(ccdtg_pkg::SHUT_CYC))
        else $error("shutter width wrong");
    pd_xfer_a: assert property ($rose(o_vert_phase_one_xfer) |->
        (o_vert_phase_one && o_frame_busy && !o_horiz_phase_two) [*8])
        else $error("photodiode transfer malformed");
    word_hold_a: assert property (o_pix_valid && !i_pix_ready |=>
        o_pix_valid && $stable(o_pix_data))
        else $error("stalled word changed");
endmodule // ccdtg_timing_assertions
bind ccdtg_timing ccdtg_timing_assertions #(.STAGES(STAGES), .ROWS(ROWS)) u_chk (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pix_ready(i_pix_ready),
    .o_vert_phase_one(o_vert_phase_one), .o_vert_phase_one_xfer(o_vert_phase_one_xfer),
    .o_vert_phase_two(o_vert_phase_two), .o_horiz_a_phase_one(o_horiz_a_phase_one),
    .o_horiz_b_phase_one(o_horiz_b_phase_one), .o_horiz_phase_two(o_horiz_phase_two),
    .o_reset_clock(o_reset_clock), .o_line_dump_gate(o_line_dump_gate),
    .o_shutter_pulse(o_shutter_pulse), .o_pix_valid(o_pix_valid),
    .o_pix_data(o_pix_data), .o_frame_busy(o_frame_busy)
);
`default_nettype wire

// File: dv/ccdtg_sensor_model.sv
// behavioural image sensor: charge moves as row sums, pixel = row*64 + column
// assumes the timing generator's registered clocks and a converter per output
`timescale 1ns/1ps
`default_nettype none
module ccdtg_sensor_model (
    // sensor clocks from the generator
    input wire logic i_clk,
    input wire logic i_v1x,
    input wire logic i_v2,
    input wire logic i_h1a,
    input wire logic i_h1b,
    input wire logic i_h2,
    input wire logic i_dump,
    // converted output levels
    output logic [11:0] o_adc_a,
    output logic [11:0] o_adc_b
);
    int nrow = 0, col = 0, a_sum = 0, a_n = 0, b_sum = 0, b_n = 0;
    bit v1x_q = 0, v2_q = 0, mv_q = 0, dseen = 0;
    initial {o_adc_a, o_adc_b} = '0;
    // =========================================================
    // vertical side, sampled on the clock so it never races the generator
    always @(posedge i_clk) begin
        if (i_v1x && !v1x_q) begin
            nrow = 0;
            col = 0;
            {a_sum, a_n, b_sum, b_n} = '0;
        end
        if (v2_q && !i_v2) begin
            if (col != 0) begin // last line already shifted out
                {a_sum, a_n, b_sum, b_n} = '0;
                col = 0;
            end
            if (!(dseen || i_dump)) begin
                a_sum += nrow;
                a_n++;
            end
            dseen = 0;
            nrow++;
        end
        if (i_dump && !i_v2) begin
            a_sum = 0;
            a_n = 0;
        end else if (i_dump) begin
            dseen = 1;
        end
        if (!i_h1a && i_h1b && !i_h2 && !mv_q) begin
            b_sum = a_sum;
            b_n = a_n;
            a_sum = 0;
            a_n = 0;
        end
        mv_q = !i_h1a && i_h1b && !i_h2;
        v1x_q = i_v1x;
        v2_q = i_v2;
    end
    // next packet lands on both nodes as phase two falls
    always @(negedge i_h2) begin
        o_adc_a = 12'(a_sum * 64 + a_n * col);
        o_adc_b = 12'(b_sum * 64 + b_n * col);
        col++;
    end
endmodule // ccdtg_sensor_model
`default_nettype wire

// File: dv/ccdtg_timing_tb.sv
// self-checking bench: generator, sensor model and a queue reference
// assumes the checker binds itself; sizes shrunk through STAGES and ROWS
`timescale 1ns/1ps
`default_nettype none
module ccdtg_timing_tb;
    import ccdtg_pkg::*;
    localparam int ST = 36;
    localparam int RW = 16;
    logic i_clk, i_sys_rst, i_run, i_dual_mode, i_bin_two, i_pix_ready, v1, v1x, v2;
    logic h1a, h1b, h2, rclk, dump, shut, pvalid, busy;
    logic [ROW_W-1:0] i_dump_rows, i_shutter_group;
    logic [ADC_W-1:0] adc_a, adc_b;
    logic [PIX_W-1:0] pdata;
    logic [PIX_W-1:0] exp_q[$];
    int miscompares = 0, checks = 0, seed = 32'h9b04, stall = 0, shots = 0, l1, l2;
    // =========================================================
    // generator and the sensor it drives
    ccdtg_timing #(.STAGES(ST), .ROWS(RW)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_run(i_run), .i_dual_mode(i_dual_mode),
        .i_bin_two(i_bin_two), .i_dump_rows(i_dump_rows), .i_shutter_group(i_shutter_group),
        .i_adc_a(adc_a), .i_adc_b(adc_b), .o_vert_phase_one(v1), .o_vert_phase_one_xfer(v1x),
        .o_vert_phase_two(v2), .o_horiz_a_phase_one(h1a), .o_horiz_b_phase_one(h1b),
        .o_horiz_phase_two(h2), .o_reset_clock(rclk), .o_line_dump_gate(dump),
        .o_shutter_pulse(shut), .o_pix_valid(pvalid), .o_pix_data(pdata),
        .i_pix_ready(i_pix_ready), .o_frame_busy(busy)
    );
    ccdtg_sensor_model sensor (
        .i_clk(i_clk), .i_v1x(v1x), .i_v2(v2), .i_h1a(h1a), .i_h1b(h1b), .i_h2(h2),
        .i_dump(dump), .o_adc_a(adc_a), .o_adc_b(adc_b)
    );
    // 200 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic check(input logic [PIX_W-1:0] seen, input logic [PIX_W-1:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic int pix(input int r, input int c);
        return r * 64 + c;
    endfunction
    // each accepted word against the head of the reference queue
    always @(posedge i_clk) begin
        if (!i_sys_rst && pvalid === 1'b1 && i_pix_ready) begin
            check(pdata, (exp_q.size() > 0) ? exp_q.pop_front() : ~pdata);
        end
    end
    // consumer: random back-pressure, or a long stall to fill the fifo
    always @(posedge i_clk) begin
        #1;
        i_pix_ready = (stall == 0) && (($random(seed) & 3) != 0);
        if (stall > 0) stall--;
    end
    always @(posedge shut) shots++;
    // one frame: build the reference, start it, wait for idle, tally
    task automatic run_frame(input bit dual, input bit bin, input int dumps, input int shg,
                             output int len);
        int n, r, c, k, av, bv;
        n = bin ? 2 : 1;
        for (r = 0; r < RW; r += dual ? 2 * n : n) begin
            for (c = 0; c < ST && r >= dumps; c++) begin
                av = 0;
                bv = 0;
                for (k = 0; k < n; k++) begin
                    if (dual) bv += pix(r + k, c);
                    av += pix(r + k + (dual ? n : 0), c);
                end
                exp_q.push_back({(r < DARK_ROWS || c < DARK_COLS), bv[11:0], av[11:0]});
            end
        end
        shots = 0;
        i_dual_mode = dual;
        i_bin_two = bin;
        i_dump_rows = ROW_W'(dumps);
        i_shutter_group = ROW_W'(shg);
        i_run = 1'b1;
        for (len = 0; len < 20 && busy !== 1'b1; len++) @(posedge i_clk);
        #1;
        i_run = 1'b0;
        for (len = 0; len < 60000 && busy === 1'b1; len++) @(posedge i_clk);
        repeat (200) @(posedge i_clk);
        #1;
        check(PIX_W'(exp_q.size()), '0);
        check(PIX_W'(shots), PIX_W'(1));
        check(PIX_W'(busy), '0);
    endtask
    // =========================================================
    // main sequence
    initial begin
        {i_sys_rst, i_run, i_dual_mode, i_bin_two, i_pix_ready} = 5'h10;
        {i_dump_rows, i_shutter_group} = '0;
        repeat (12) @(posedge i_clk);
        #1;
        check(PIX_W'({v1, v1x, v2, h1a, h1b, h2, rclk, dump, shut, pvalid, busy}),
              PIX_W'(11'h100));
        i_sys_rst = 1'b0;
        run_frame(1'b0, 1'b0, 2, 3, l1);
        run_frame(1'b0, 1'b0, 2, 12, l2);
        check(PIX_W'(l1), PIX_W'(l2));
        fork
            run_frame(1'b1, 1'b0, 0, $random(seed) & 3, l1);
            begin
                wait (pvalid === 1'b1);
                stall = 300;
                repeat (250) @(posedge i_clk);
                #1;
                check(PIX_W'({pvalid, h2, h1a}), PIX_W'(3'h6));
            end
        join
        run_frame(1'b0, 1'b1, 0, $random(seed) & 3, l1);
        run_frame(1'b1, 1'b1, 0, $random(seed) & 3, l2);
        give_verdict();
    end
    // hang guard: five frames need about 78k cycles, give up at 90k
    initial begin
        repeat (90000) @(posedge i_clk);
        miscompares++;
        give_verdict();
    end
endmodule // ccdtg_timing_tb
`default_nettype wire
